// >>> logic/position_counter.sv
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "position_counter_cfg.svh"

module position_counter #(
	parameter int SCAN_50HZ_CYCLES = `SCAN_50HZ_NS / `CLK_PERIOD_NS,
	parameter int SCAN_60HZ_CYCLES = `SCAN_60HZ_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic                                clk,
	input  wire logic                                reset_n,
	// avalon-mm slave
	input  wire logic [3:0]                          address,
	input  wire logic                                read,
	input  wire logic                                write,
	input  wire logic [31:0]                         writedata,
	input  wire logic [3:0]                          byteenable,
	output logic [31:0]                              readdata,
	output logic                                     waitrequest,
	// encoder and digital input pins
	input  wire position_counter_pkg::encoder_pins_s pins,
	// mains frequency: high selects the 60 Hz scan period
	input  wire logic                                mains_60hz,
	// position outputs
	output logic [15:0]                              position_low_word,
	output logic [15:0]                              position_high_word,
	output logic                                     sync_done_flag
);

	typedef struct packed {
		position_counter_pkg::sw_regs_s     regs;
		position_counter_pkg::encoder_pins_s sync1;
		position_counter_pkg::encoder_pins_s sync2;
		logic signed [31:0]                 position;
		logic                               sync_done_flag;
		logic                               zero_prev;
		logic                               input_sample;
		logic [23:0]                        scan_count;
		logic                               answered;
		logic [31:0]                        readdata;
		logic [15:0]                        low_snapshot;
	} state_s;

	state_s state;
	state_s next_state;

	logic                             step_up;
	logic                             step_down;
	logic                             encoder_selected;
	logic                             cyclic;
	logic                             inhibit;
	logic                             software_sync;
	logic                             hardware_sync;
	logic                             sync_event;
	logic                             accept;
	logic                             scan_tick;
	logic [23:0]                      scan_limit;
	position_counter_pkg::sync_source_e sync_trigger_source;
	position_counter_pkg::edge_mode_e encoder_edge_mode;
	logic                             wr;
	logic                             rd;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] be);
		merge16 = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
	endfunction : merge16

	quadrature_decoder u_decoder (
		.clk              (clk),
		.reset_n          (reset_n),
		.a                (state.sync2.a),
		.b                (state.sync2.b),
		.encoder_edge_mode(encoder_edge_mode),
		.step_up          (step_up),
		.step_down        (step_down)
	);

	always_comb begin
		encoder_selected    = state.regs.config_word[`BIT_FB_ENCODER];
		cyclic              = state.regs.config_word[`BIT_CYCLIC];
		sync_trigger_source = position_counter_pkg::sync_source_e'(state.regs.config_word[`POS_SRC +: 2]);
		encoder_edge_mode   = position_counter_pkg::edge_mode_e'(state.regs.config_word[`POS_EDGE +: 2]);
		inhibit             = state.regs.auxiliary_control_word[`BIT_SYNC_INHIBIT];
		software_sync       = state.regs.auxiliary_control_word[`BIT_SYNC_COMMAND];
		scan_limit          = mains_60hz ? 24'(SCAN_60HZ_CYCLES - 1) : 24'(SCAN_50HZ_CYCLES - 1);
		scan_tick           = (state.scan_count >= scan_limit);
		// a write lands only at the edge where waitrequest is seen low
		wr                  = write && state.answered;
		rd                  = read && !state.answered;
	end

	// trigger selection and acceptance
	always_comb begin
		hardware_sync = 1'b0;
		unique case (sync_trigger_source)
			position_counter_pkg::SRC_ZERO_PULSE:    hardware_sync = state.sync2.zero && !state.zero_prev;
			position_counter_pkg::SRC_DIGITAL_INPUT:
				hardware_sync = scan_tick && state.sync2.digital_input_seven && !state.input_sample;
			default:                                 hardware_sync = 1'b0;
		endcase
		sync_event = (sync_trigger_source == position_counter_pkg::SRC_SOFTWARE) ? software_sync
			: hardware_sync;
		// single mode holds off while done is set; cyclic takes every event that is not inhibited
		accept = sync_event && !inhibit && (cyclic || !state.sync_done_flag);
	end

	always_comb begin
		next_state       = state;
		next_state.sync1 = pins;
		next_state.sync2 = state.sync1;
		next_state.zero_prev = state.sync2.zero;
		next_state.scan_count = scan_tick ? 24'h000000 : state.scan_count + 24'h000001;
		if (scan_tick) begin
			next_state.input_sample = state.sync2.digital_input_seven;
		end

		// counting, with preset taking priority
		if (accept) begin
			next_state.position = $signed({state.regs.preset_high_word, state.regs.preset_low_word});
		end else if (encoder_selected && step_up) begin
			next_state.position = state.position + 32'sh00000001;
		end else if (encoder_selected && step_down) begin
			next_state.position = state.position - 32'sh00000001;
		end

		// a clear that meets a new sync loses to the set
		if (wr && address == `OFS_AUX_CTRL && byteenable[1] && writedata[`BIT_SYNC_CLEAR]) begin
			next_state.sync_done_flag = 1'b0;
		end
		if (accept) begin
			next_state.sync_done_flag = 1'b1;
		end

		// avalon slave: one wait cycle, answered on the second edge
		next_state.answered = (read || write) && !state.answered;
		if (wr) begin
			unique case (address)
				`OFS_AUX_CTRL:    next_state.regs.auxiliary_control_word =
					merge16(state.regs.auxiliary_control_word, writedata, byteenable);
				`OFS_CONFIG:      next_state.regs.config_word = merge16(state.regs.config_word, writedata, byteenable);
				`OFS_PRESET_LOW:  next_state.regs.preset_low_word =
					merge16(state.regs.preset_low_word, writedata, byteenable);
				`OFS_PRESET_HIGH: next_state.regs.preset_high_word =
					merge16(state.regs.preset_high_word, writedata, byteenable);
				default:          next_state.regs = state.regs;
			endcase
		end
		if (rd) begin
			unique case (address)
				`OFS_AUX_CTRL:      next_state.readdata = {16'h0000, state.regs.auxiliary_control_word};
				`OFS_AUX_STAT:      next_state.readdata = 32'(state.sync_done_flag) << `BIT_SYNC_DONE;
				`OFS_CONFIG:        next_state.readdata = {16'h0000, state.regs.config_word};
				`OFS_PRESET_LOW:    next_state.readdata = {16'h0000, state.regs.preset_low_word};
				`OFS_PRESET_HIGH:   next_state.readdata = {16'h0000, state.regs.preset_high_word};
				`OFS_POSITION_LOW:  next_state.readdata = {16'h0000, state.position[15:0]};
				`OFS_POSITION_HIGH: next_state.readdata = {16'h0000, state.position[31:16]};
				default:            next_state.readdata = 32'h00000000;
			endcase
		end
		next_state.low_snapshot = state.position[15:0];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state                             <= '0;
			state.regs.auxiliary_control_word <= `RST_AUX_CTRL;
			state.regs.config_word            <= `RST_CONFIG;
			state.regs.preset_low_word        <= `RST_PRESET;
			state.regs.preset_high_word       <= `RST_PRESET;
		end else begin
			state <= next_state;
		end
	end

	assign waitrequest        = (read || write) && !state.answered;
	assign readdata           = state.readdata;
	assign position_low_word  = state.position[15:0];
	assign position_high_word = state.position[31:16];
	assign sync_done_flag     = state.sync_done_flag;

	// sequences for a preset
	sequence s_accepted;
		accept;
	endsequence

	sequence s_loaded;
		##1 {position_high_word, position_low_word} ==
			$past({state.regs.preset_high_word, state.regs.preset_low_word});
	endsequence

	property p_preset;
		@(posedge clk) disable iff (!reset_n) s_accepted |-> s_loaded;
	endproperty

	a_preset_loads_value: assert property (p_preset) else $error("preset not loaded");
	a_done_sets: assert property (@(posedge clk) disable iff (!reset_n)
		accept |=> sync_done_flag) else $error("done flag not set");
	a_inhibit_blocks: assert property (@(posedge clk) disable iff (!reset_n)
		inhibit |-> !accept) else $error("sync taken while inhibited");
	a_feedback_gate: assert property (@(posedge clk) disable iff (!reset_n)
		!encoder_selected && !accept |=> $stable(state.position)) else $error("count moved");
	a_count_up: assert property (@(posedge clk) disable iff (!reset_n)
		encoder_selected && step_up && !accept |=> state.position == $past(state.position) + 1)
		else $error("no increment");
	a_count_down: assert property (@(posedge clk) disable iff (!reset_n)
		encoder_selected && step_down && !accept |=> state.position == $past(state.position) - 1)
		else $error("no decrement");
	a_single_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!cyclic && sync_done_flag |-> !accept) else $error("single mode re-synced");
	a_cyclic_every: assert property (@(posedge clk) disable iff (!reset_n)
		cyclic && sync_event && !inhibit |-> accept) else $error("cyclic event lost");
	a_clear_done: assert property (@(posedge clk) disable iff (!reset_n)
		wr && address == `OFS_AUX_CTRL && byteenable[1] && writedata[`BIT_SYNC_CLEAR] && !accept
		|=> !sync_done_flag) else $error("done flag not cleared");
	a_slave_answer: assert property (@(posedge clk) disable iff (!reset_n)
		(read || write) && waitrequest |=> !waitrequest || !(read || write)) else $error("slave stalled");

endmodule : position_counter
`default_nettype wire

// >>> logic/position_counter_cfg.svh
`ifndef POSITION_COUNTER_CFG_SVH
`define POSITION_COUNTER_CFG_SVH

// register word offsets
`define OFS_AUX_CTRL       4'h0
`define OFS_AUX_STAT       4'h1
`define OFS_CONFIG         4'h2
`define OFS_PRESET_LOW     4'h3
`define OFS_PRESET_HIGH    4'h4
`define OFS_POSITION_LOW   4'h5
`define OFS_POSITION_HIGH  4'h6

// auxiliary control word bits
`define BIT_SYNC_COMMAND   9
`define BIT_SYNC_INHIBIT   10
`define BIT_SYNC_CLEAR     11
// auxiliary status word bits
`define BIT_SYNC_DONE      5
// configuration word fields
`define BIT_FB_ENCODER     0
`define BIT_CYCLIC         1
`define POS_SRC            2
`define POS_EDGE           4

// reset values
`define RST_AUX_CTRL       16'h0000
`define RST_CONFIG         16'h0000
`define RST_PRESET         16'h0000

// digital input seven scan period, 50 Hz and 60 Hz mains
`define SCAN_50HZ_NS       3300000
`define SCAN_60HZ_NS       2770000
`define CLK_PERIOD_NS      4

`endif

// >>> logic/position_counter_pkg.sv
`default_nettype none
package position_counter_pkg;

	typedef enum logic [1:0] {
		SRC_SOFTWARE = 2'h0,
		SRC_ZERO_PULSE = 2'h1,
		SRC_DIGITAL_INPUT = 2'h2
	} sync_source_e;

	typedef enum logic [1:0] {
		EDGE_A_RISE = 2'h0,
		EDGE_A_BOTH = 2'h1,
		EDGE_AB_ALL = 2'h2
	} edge_mode_e;

	typedef struct packed {
		logic       a;
		logic       b;
		logic       zero;
		logic       digital_input_seven;
	} encoder_pins_s;

	typedef struct packed {
		logic [15:0] auxiliary_control_word;
		logic [15:0] config_word;
		logic [15:0] preset_low_word;
		logic [15:0] preset_high_word;
	} sw_regs_s;

endpackage : position_counter_pkg
`default_nettype wire

// >>> logic/quadrature_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "position_counter_cfg.svh"

module quadrature_decoder (
	// clock and reset
	input  wire logic                             clk,
	input  wire logic                             reset_n,
	// synchronised encoder tracks
	input  wire logic                             a,
	input  wire logic                             b,
	input  wire position_counter_pkg::edge_mode_e encoder_edge_mode,
	// count step
	output logic                                  step_up,
	output logic                                  step_down
);

	typedef struct packed {
		logic a;
		logic b;
	} state_s;

	state_s state;
	state_s next_state;
	logic   a_edge;
	logic   b_edge;
	logic   forward;
	logic   valid;

	always_comb begin
		next_state.a = a;
		next_state.b = b;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// direction from the quadrature phase relation at the changing track
	always_comb begin
		a_edge  = a ^ state.a;
		b_edge  = b ^ state.b;
		forward = a_edge ? (a ^ b) : ~(a ^ b);
		valid   = 1'b0;
		unique case (encoder_edge_mode)
			position_counter_pkg::EDGE_A_RISE: valid = a_edge && a;
			position_counter_pkg::EDGE_A_BOTH: valid = a_edge;
			position_counter_pkg::EDGE_AB_ALL: valid = a_edge ^ b_edge;
			default:                           valid = 1'b0;
		endcase
		step_up   = valid && forward;
		step_down = valid && !forward;
	end

endmodule : quadrature_decoder
`default_nettype wire

// >>> test/encoder_model.sv
`timescale 1ns/100ps
`default_nettype none
// incremental encoder on the motor shaft: two quadrature tracks and a zero pulse
module encoder_model (
	// step clock
	input  wire logic clk,
	// encoder tracks
	output logic      a,
	output logic      b,
	output logic      zero
);
	logic [1:0] phase;
	initial begin
		{a, b, zero, phase} = 5'h00;
	end
	// gap sets the speed, so prompt and slow motion both reach the decoder
	task automatic turn(input logic fwd, input int quarters, input int gap);
		for (int i = 0; i < quarters; i++) begin
			repeat (gap) @(posedge clk);
			phase = fwd ? phase + 2'h1 : phase - 2'h1;
			// forward means track a leads track b
			a <= phase[1] ^ phase[0];
			b <= phase[1];
		end
	endtask : turn
	task automatic index_pulse(input int width);
		@(posedge clk);
		zero <= 1'b1;
		repeat (width) @(posedge clk);
		zero <= 1'b0;
	endtask : index_pulse
endmodule : encoder_model
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic                                clk, reset_n, read, write, waitrequest, sync_done_flag;
	logic                                mains_60hz, din7, a, b, zero;
	logic [3:0]                          address, byteenable;
	logic [31:0]                         writedata, readdata, pos;
	logic [15:0]                         position_low_word, position_high_word;
	position_counter_pkg::encoder_pins_s pins;
	int                                  fail_count, samples_checked, seed, n, lat;
	logic [31:0]                         q[$];
	assign pins = {a, b, zero, din7};
	encoder_model enc (.clk(clk), .a(a), .b(b), .zero(zero));
	position_counter #(.SCAN_50HZ_CYCLES(20), .SCAN_60HZ_CYCLES(16)) dut (
		.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.pins(pins), .mains_60hz(mains_60hz), .position_low_word(position_low_word),
		.position_high_word(position_high_word), .sync_done_flag(sync_done_flag)
	);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checked %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : cmp
	// read data is judged at the completing edge, oldest note first
	always @(posedge clk) begin
		if (read === 1'b1 && waitrequest === 1'b0)
			cmp((q.size() > 0) ? q.pop_front() : 32'hFFFF_FFFF, readdata);
	end
	task automatic bus_op(input logic w, input logic [3:0] adr, input logic [15:0] d);
		int k = 0;
		@(posedge clk);
		{read, write} <= {~w, w};
		{address, writedata} <= {adr, 16'h0000, d};
		do @(posedge clk); while (waitrequest !== 1'b0 && ++k < 50);
		if (waitrequest !== 1'b0) begin
			fail_count++;
			print_verdict();
		end
		{read, write} <= 2'b00;
	endtask : bus_op
	task automatic wr(input logic [3:0] adr, input logic [15:0] d);
		bus_op(1'b1, adr, d);
	endtask : wr
	task automatic rd(input logic [3:0] adr, input logic [15:0] exp);
		q.push_back({16'h0000, exp});
		bus_op(1'b0, adr, 16'h0000);
	endtask : rd
	// pins pass a two-flop synchroniser and the decoder before the count moves
	task automatic chk_pos();
		repeat (6) @(posedge clk);
		rd(4'h5, pos[15:0]);
		rd(4'h6, pos[31:16]);
	endtask : chk_pos
	task automatic aux(input logic [15:0] d);
		wr(4'h0, d);
		wr(4'h0, 16'h0000);
	endtask : aux
	task automatic preset(input logic [31:0] v);
		wr(4'h3, v[15:0]);
		wr(4'h4, v[31:16]);
	endtask : preset
	function automatic logic [15:0] cfg(input logic [1:0] src, input logic cyc, input logic [1:0] edg);
		return {10'h000, edg, src, cyc, 1'b1};
	endfunction : cfg
	initial begin
		seed = 32'h6c9b6918;
		{reset_n, read, write, mains_60hz, din7} = 5'h00;
		{address, byteenable, writedata, pos} = {4'h0, 4'hF, 64'h0};
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(4'(i), 16'h0000);
		wr(4'h5, 16'h1234);
		wr(4'h9, 16'h5555);
		rd(4'h5, 16'h0000);
		rd(4'h9, 16'h0000);
		enc.turn(1'b1, 8, 1);
		chk_pos();
		$display("test reset done");
		for (int m = 0; m < 3; m++) begin
			wr(4'h2, cfg(2'h0, 1'b0, 2'(m)));
			enc.turn(1'b0, 4, 1 + m);
			pos = pos - (32'h1 << m);
			chk_pos();
			enc.turn(1'b1, 8, 1);
			pos = pos + (32'h2 << m);
			chk_pos();
		end
		$display("test edge modes done");
		preset(32'h0000_FFFE);
		aux(16'h0200);
		pos = 32'h0000_FFFE;
		chk_pos();
		rd(4'h1, 16'h0020);
		enc.turn(1'b1, 4, 1);
		pos = pos + 32'h4;
		chk_pos();
		n = $random(seed);
		preset(n);
		aux(16'h0200);
		chk_pos();
		aux(16'h0800);
		rd(4'h1, 16'h0000);
		wr(4'h0, 16'h0400);
		wr(4'h0, 16'h0600);
		wr(4'h0, 16'h0000);
		rd(4'h1, 16'h0000);
		chk_pos();
		aux(16'h0200);
		pos = n;
		chk_pos();
		rd(4'h1, 16'h0020);
		$display("test software sync done");
		aux(16'h0800);
		n = $random(seed);
		preset(n);
		wr(4'h2, cfg(2'h1, 1'b0, 2'h2));
		enc.index_pulse(1);
		pos = n;
		chk_pos();
		wr(4'h2, cfg(2'h1, 1'b1, 2'h2));
		enc.turn(1'b1, 4, 1);
		enc.index_pulse(2);
		chk_pos();
		wr(4'h2, cfg(2'h0, 1'b1, 2'h2));
		wr(4'h0, 16'h0200);
		enc.turn(1'b1, 8, 2);
		chk_pos();
		wr(4'h0, 16'h0000);
		$display("test hardware and cyclic sync done");
		for (int m = 0; m < 2; m++) begin
			aux(16'h0800);
			mains_60hz <= m[0];
			n = $random(seed);
			preset(n);
			wr(4'h2, cfg(2'h2, 1'b0, 2'h2));
			enc.index_pulse(1);
			rd(4'h1, 16'h0000);
			din7 <= 1'b1;
			for (lat = 0; lat < 60 && sync_done_flag !== 1'b1; lat++)
				@(posedge clk);
			cmp(32'h1, 32'(lat <= (m ? 16 : 20) + 6));
			din7 <= 1'b0;
			pos = n;
			chk_pos();
		end
		$display("test digital input sync done");
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
